/* hw/tsr_pkg.sv */
`default_nettype none

package tsr_pkg;

    // Pointer values of the implemented registers.
    localparam logic [3:0] PTR_CAPABILITY  = 4'h0;
    localparam logic [3:0] PTR_CONFIG      = 4'h1;
    localparam logic [3:0] PTR_UPPER       = 4'h2;
    localparam logic [3:0] PTR_LOWER       = 4'h3;
    localparam logic [3:0] PTR_CRITICAL    = 4'h4;
    localparam logic [3:0] PTR_AMBIENT     = 4'h5;
    localparam logic [3:0] PTR_MAKER       = 4'h6;
    localparam logic [3:0] PTR_PART        = 4'h7;
    localparam logic [3:0] PTR_PART_ALT    = 4'h8;
    localparam logic [3:0] PTR_STEP_SIZE   = 4'h9;
    localparam logic [7:0] PTR_BYTE_LAST   = 8'h09;

    // Fixed capability fields.
    localparam logic       CAP_SHUTDOWN_EVENT_BEHAVIOUR = 1'b1;
    localparam logic       CAP_BUS_TIMEOUT_WINDOW       = 1'b1;
    localparam logic       CAP_RAISED_VOLTAGE_PIN       = 1'b1;
    localparam logic       CAP_NEGATIVE_RANGE           = 1'b1;
    localparam logic       CAP_ACCURACY                 = 1'b1;
    localparam logic       CAP_ALARM                    = 1'b1;

    // Configuration field positions and masks, and the limit write mask.
    localparam int         CFG_CRIT_LOCK_BIT   = 7;
    localparam int         CFG_WIN_LOCK_BIT    = 6;
    localparam int         CFG_INT_CLEAR_BIT   = 5;
    localparam int         CFG_EVENT_STAT_BIT  = 4;
    localparam logic [15:0] CFG_STORE_MASK     = 16'h07cf;
    localparam logic [15:0] CFG_LOCK_MASK      = 16'h00c0;
    localparam logic [15:0] LIMIT_WRITE_MASK   = 16'h1ffc;

    // Values after reset.
    localparam logic [15:0] CONFIG_RESET       = 16'h0000;
    localparam logic [15:0] LIMIT_RESET        = 16'h0000;
    localparam logic [1:0]  STEP_SIZE_RESET    = 2'h1;
    localparam logic [3:0]  PTR_RESET          = 4'h0;

    // Bus time-out timing.
    localparam int unsigned CLK_PERIOD_NS          = 4;
    localparam int unsigned BUS_TIMEOUT_MIN_MS     = 25;
    localparam int unsigned BUS_TIMEOUT_MAX_MS     = 35;
    localparam int unsigned BUS_TIMEOUT_ALT_MIN_MS = 10;
    localparam int unsigned BUS_TIMEOUT_ALT_MAX_MS = 60;
    localparam int unsigned BUS_TIMEOUT_CYCLES =
        (BUS_TIMEOUT_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          TIMEOUT_CNT_W          = 24;

    typedef enum logic [3:0] {
        TSR_WP_IDLE = 4'b0001,
        TSR_WP_PTR  = 4'b0010,
        TSR_WP_MSB  = 4'b0100,
        TSR_WP_LSB  = 4'b1000
    } tsr_wphase_t;

    // Byte-level requests from the serial engine.
    typedef struct packed {
        logic       start;
        logic       rnw;
        logic       wr_valid;
        logic [7:0] wr_byte;
        logic       rd_req;
    } tsr_req_t;

    // Answers to the serial engine.
    typedef struct packed {
        logic       ack_valid;
        logic       ack;
        logic       rd_valid;
        logic [7:0] rd_byte;
    } tsr_ans_t;

    typedef struct packed {
        logic [15:0] upper;
        logic [15:0] lower;
        logic [15:0] critical;
    } tsr_limits_t;

    typedef struct packed {
        tsr_wphase_t wphase;
        logic [3:0]  ptr;
        logic [7:0]  wr_msb;
        logic        rd_lsb;
        logic [15:0] config_r;
        tsr_limits_t limits;
        logic [1:0]  step_size;
        logic        int_clear;
        tsr_ans_t    ans;
    } tsr_bank_state_t;

    localparam tsr_bank_state_t TSR_BANK_RESET = '{
        wphase:    TSR_WP_IDLE,
        ptr:       PTR_RESET,
        wr_msb:    8'h00,
        rd_lsb:    1'b0,
        config_r:  CONFIG_RESET,
        limits:    '{upper: LIMIT_RESET, lower: LIMIT_RESET, critical: LIMIT_RESET},
        step_size: STEP_SIZE_RESET,
        int_clear: 1'b0,
        ans:       '{ack_valid: 1'b0, ack: 1'b0, rd_valid: 1'b0, rd_byte: 8'h00}
    };

    typedef struct packed {
        logic [TIMEOUT_CNT_W-1:0] count;
        logic                     scl_last;
        logic                     fire;
    } tsr_wdog_state_t;

    localparam tsr_wdog_state_t TSR_WDOG_RESET = '{
        count:    24'h000000,
        scl_last: 1'b1,
        fire:     1'b0
    };

endpackage : tsr_pkg

`default_nettype wire

/* hw/tsr_bus_watchdog.sv */
`default_nettype none

module tsr_bus_watchdog
#(
    parameter logic [23:0] TIMEOUT_CYCLES = 24'd6250000
)
(
    // Clock and reset
    input  wire logic mclk_i,
    input  wire logic resetn_i,
    // Bus observation
    input  wire logic scl_i,
    input  wire logic busy_i,
    // Time-out event
    output logic      timeout_o
);
    import tsr_pkg::*;

    tsr_wdog_state_t s;
    tsr_wdog_state_t next_s;

    // Counting only inside a transaction keeps an idle, high bus from resetting itself.
    always_comb
    begin
        next_s          = s;
        next_s.fire     = 1'b0;
        next_s.scl_last = scl_i;
        if (!busy_i || scl_i != s.scl_last)
        begin
            next_s.count = '0;
        end
        else if (s.count == TIMEOUT_CYCLES - 24'd1)
        begin
            next_s.fire  = 1'b1;
            next_s.count = '0;
        end
        else
        begin
            next_s.count = s.count + 24'd1;
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            s <= TSR_WDOG_RESET;
        else
            s <= next_s;
    end

    assign timeout_o = s.fire;

endmodule : tsr_bus_watchdog

`default_nettype wire

/* hw/tsr_register_bank.sv */
`default_nettype none

module tsr_register_bank
#(
    parameter int unsigned BUS_TIMEOUT_CYCLES = tsr_pkg::BUS_TIMEOUT_CYCLES,
    parameter logic [15:0] MAKER_CODE         = 16'h0a5a, // Arbitrary value.
    parameter logic [15:0] PART_CODE          = 16'h5a01, // Arbitrary value.
    parameter logic [15:0] PART_CODE_ALT      = 16'h5a02  // Arbitrary value.
)
(
    // Clock and reset
    input  wire logic               mclk_i,
    input  wire logic               resetn_i,
    // Serial engine byte port
    input  wire tsr_pkg::tsr_req_t  req_i,
    input  wire logic               bus_busy_i,
    input  wire logic               scl_i,
    output tsr_pkg::tsr_ans_t       ans_o,
    output logic                    serial_reset_o,
    // Conversion and event engine
    input  wire logic [15:0]        ambient_temperature_i,
    input  wire logic               event_stat_i,
    output logic [15:0]             config_o,
    output tsr_pkg::tsr_limits_t    limits_o,
    output logic [1:0]              step_size_o,
    output logic                    int_clear_o
);
    import tsr_pkg::*;

    tsr_bank_state_t s;
    tsr_bank_state_t next_s;
    logic            timeout;
    logic [15:0]     rd_word;
    // Word formed from the held high byte and the byte now arriving.
    logic [15:0]     wr_word;
    logic [7:0]      cap_low;

    // The watchdog resets only the byte state, never the register contents.
    tsr_bus_watchdog
    #(
        .TIMEOUT_CYCLES (BUS_TIMEOUT_CYCLES[23:0])
    )
    u_watchdog
    (
        .mclk_i    (mclk_i),
        .resetn_i  (resetn_i),
        .scl_i     (scl_i),
        .busy_i    (bus_busy_i),
        .timeout_o (timeout)
    );

    // The low byte is fixed at build time except for the step-size field, which follows
    // the live select so that software always sees the resolution actually in use.
    always_comb
    begin
        cap_low = {CAP_SHUTDOWN_EVENT_BEHAVIOUR,
                   CAP_BUS_TIMEOUT_WINDOW,
                   CAP_RAISED_VOLTAGE_PIN,
                   s.step_size,
                   CAP_NEGATIVE_RANGE,
                   CAP_ACCURACY,
                   CAP_ALARM};
    end

    // Read data selected by the held pointer.
    always_comb
    begin
        case (s.ptr)
            PTR_CAPABILITY: rd_word = {8'h00, cap_low};
            PTR_CONFIG:
            begin
                // The status bit is live rather than stored, so a read shows the current event.
                rd_word = s.config_r;
                rd_word[CFG_EVENT_STAT_BIT] = event_stat_i;
            end
            PTR_UPPER:      rd_word = s.limits.upper;
            PTR_LOWER:      rd_word = s.limits.lower;
            PTR_CRITICAL:   rd_word = s.limits.critical;
            PTR_AMBIENT:    rd_word = ambient_temperature_i;
            PTR_MAKER:      rd_word = MAKER_CODE;
            PTR_PART:       rd_word = PART_CODE;
            PTR_PART_ALT:   rd_word = PART_CODE_ALT;
            PTR_STEP_SIZE:  rd_word = {14'h0000, s.step_size};
            // Unreachable while the pointer check holds, but keeps the decode complete.
            default:        rd_word = 16'h0000;
        endcase
    end

    // One byte request is handled per cycle: start wins over a write byte, and a write
    // byte wins over a read request. Every answer is registered, so the serial engine
    // sees it exactly one cycle after its strobe.
    always_comb
    begin
        next_s           = s;
        next_s.ans       = '0;
        next_s.int_clear = 1'b0;
        wr_word          = {s.wr_msb, req_i.wr_byte};
        if (timeout)
        begin
            // A half-finished write is dropped; the pointer survives, so a later read
            // frame still lands on the last selected register.
            next_s.wphase = TSR_WP_IDLE;
            next_s.rd_lsb = 1'b0;
        end
        else if (req_i.start)
        begin
            // A read transaction carries no pointer and reuses the held one.
            next_s.wphase = req_i.rnw ? TSR_WP_IDLE : TSR_WP_PTR;
            next_s.rd_lsb = 1'b0;
        end
        else if (req_i.wr_valid)
        begin
            next_s.ans.ack_valid = 1'b1;
            case (s.wphase)
                TSR_WP_PTR:
                begin
                    // Bits 7:4 must be zero and the low nibble must name a register.
                    if (req_i.wr_byte <= PTR_BYTE_LAST)
                    begin
                        next_s.ptr     = req_i.wr_byte[3:0];
                        next_s.ans.ack = 1'b1;
                        next_s.wphase  = TSR_WP_MSB;
                    end
                    else
                    begin
                        // The old pointer stays; later data bytes of this frame are refused.
                        next_s.ans.ack = 1'b0;
                        next_s.wphase  = TSR_WP_IDLE;
                    end
                end
                TSR_WP_MSB:
                begin
                    // A frame that stops before the low byte commits nothing.
                    next_s.wr_msb  = req_i.wr_byte;
                    next_s.ans.ack = 1'b1;
                    next_s.wphase  = TSR_WP_LSB;
                end
                TSR_WP_LSB:
                begin
                    next_s.ans.ack = 1'b1;
                    next_s.wphase  = TSR_WP_IDLE;
                    case (s.ptr)
                        PTR_CONFIG:
                        begin
                            // Lock bits stay set until reset once written.
                            next_s.config_r  = (wr_word & CFG_STORE_MASK)
                                             | (s.config_r & CFG_LOCK_MASK);
                            next_s.int_clear = wr_word[CFG_INT_CLEAR_BIT];
                        end
                        PTR_UPPER:
                        begin
                            if (!s.config_r[CFG_WIN_LOCK_BIT])
                            begin
                                next_s.limits.upper = wr_word & LIMIT_WRITE_MASK;
                            end
                        end
                        PTR_LOWER:
                        begin
                            if (!s.config_r[CFG_WIN_LOCK_BIT])
                            begin
                                next_s.limits.lower = wr_word & LIMIT_WRITE_MASK;
                            end
                        end
                        PTR_CRITICAL:
                        begin
                            if (!s.config_r[CFG_CRIT_LOCK_BIT])
                            begin
                                next_s.limits.critical = wr_word & LIMIT_WRITE_MASK;
                            end
                        end
                        PTR_STEP_SIZE:
                        begin
                            // Only the two step bits exist; the rest of the word is ignored.
                            next_s.step_size = wr_word[1:0];
                        end
                        PTR_CAPABILITY, PTR_AMBIENT, PTR_MAKER, PTR_PART, PTR_PART_ALT:
                        begin
                            // Read-only words are acknowledged and discarded; a refusal here
                            // would abort the host's frame for no gain.
                            next_s.ptr = s.ptr;
                        end
                        default:
                        begin
                            next_s.ptr = s.ptr;
                        end
                    endcase
                end
                default:
                begin
                    // No sequential access: extra bytes are refused.
                    next_s.ans.ack = 1'b0;
                end
            endcase
        end
        else if (req_i.rd_req)
        begin
            // Reads alternate high and low byte; each start begins again at the high byte.
            next_s.ans.rd_valid = 1'b1;
            next_s.ans.rd_byte  = s.rd_lsb ? rd_word[7:0] : rd_word[15:8];
            next_s.rd_lsb       = ~s.rd_lsb;
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            s <= TSR_BANK_RESET;
        end
        else
        begin
            s <= next_s;
        end
    end

    // Every output is a register copy, so no input reaches a port in the same cycle.
    assign ans_o          = s.ans;
    assign serial_reset_o = timeout;
    assign config_o       = s.config_r;
    assign limits_o       = s.limits;
    assign step_size_o    = s.step_size;
    assign int_clear_o    = s.int_clear;

endmodule : tsr_register_bank

`default_nettype wire

/* sim/tsr_register_bank_properties.sv */
`default_nettype none

module tsr_register_bank_properties
#(
    parameter int unsigned BUS_TIMEOUT_CYCLES = 50
)
(
    // Clock and reset
    input wire logic              mclk_i,
    input wire logic              resetn_i,
    // Observed ports
    input wire tsr_pkg::tsr_req_t req_i,
    input wire logic              bus_busy_i,
    input wire logic              scl_i,
    input wire tsr_pkg::tsr_ans_t ans_o,
    input wire logic              serial_reset_o,
    input wire logic [1:0]        step_size_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import tsr_pkg::*;
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!resetn_i);
    // Counts edges with a steady clock line inside a frame.
    int unsigned steady;
    logic        scl_q;
    logic        first;
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            steady <= 0;
            scl_q  <= 1'b1;
            first  <= 1'b0;
        end
        else
        begin
            steady <= (bus_busy_i && scl_i == scl_q) ? steady + 1 : 0;
            scl_q  <= scl_i;
            first  <= req_i.start ? 1'b1 : (req_i.wr_valid ? 1'b0 : first);
        end
    end
    byte_ack_a:
        assert property (req_i.wr_valid && !req_i.start |=> ans_o.ack_valid)
        else $error("write byte got no answer");
    stray_ack_a:
        assert property (ans_o.ack_valid |-> $past(req_i.wr_valid))
        else $error("answer without write byte");
    byte_read_a:
        assert property (req_i.rd_req && !req_i.start && !req_i.wr_valid |=> ans_o.rd_valid)
        else $error("read byte not delivered");
    stray_read_a:
        assert property (ans_o.rd_valid |-> $past(req_i.rd_req))
        else $error("read byte without request");
    bad_ptr_nak_a:
        assert property (first && req_i.wr_valid && !req_i.start
            && req_i.wr_byte > PTR_BYTE_LAST |=> ans_o.ack_valid && !ans_o.ack)
        else $error("bad pointer acknowledged");
    step_reset_a:
        assert property ($rose(resetn_i) |-> step_size_o == 2'h1)
        else $error("step size wrong after reset");
    timeout_early_a:
        assert property (serial_reset_o |-> steady >= BUS_TIMEOUT_CYCLES)
        else $error("bus reset too early");
    timeout_late_a:
        assert property (steady == BUS_TIMEOUT_CYCLES - 1 |-> ##[1:2] serial_reset_o)
        else $error("bus reset missing");
    idle_quiet_a:
        assert property (!bus_busy_i [*3] |-> !serial_reset_o)
        else $error("bus reset while idle");
    cover property (serial_reset_o);
    cover property (first && req_i.wr_valid && req_i.wr_byte > PTR_BYTE_LAST);
    cover property (ans_o.rd_valid && ans_o.rd_byte == 8'hef);
endmodule : tsr_register_bank_properties

bind tsr_register_bank tsr_register_bank_properties
#(
    .BUS_TIMEOUT_CYCLES(BUS_TIMEOUT_CYCLES)
)
u_props
(
    .mclk_i         (mclk_i),
    .resetn_i       (resetn_i),
    .req_i          (req_i),
    .bus_busy_i     (bus_busy_i),
    .scl_i          (scl_i),
    .ans_o          (ans_o),
    .serial_reset_o (serial_reset_o),
    .step_size_o    (step_size_o)
);

`default_nettype wire

/* sim/tsr_host_model.sv */
`default_nettype none

module tsr_host_model
(
    // Clock
    input  wire logic              mclk_i,
    // Byte port toward the bank
    input  wire tsr_pkg::tsr_ans_t ans_i,
    output tsr_pkg::tsr_req_t      req_o,
    output logic                   bus_busy_o,
    output logic                   scl_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import tsr_pkg::*;
    logic scl_hold;
    initial
    begin
        req_o      = '0;
        bus_busy_o = 1'b0;
        scl_hold   = 1'b0;
        scl_o      = 1'b1;
    end
    // The clock line rests high between frames, as its pull-up leaves it.
    always @(posedge mclk_i)
    begin
        #1;
        scl_o <= !bus_busy_o ? 1'b1 : (scl_hold ? scl_o : ~scl_o);
    end
    // A read frame needs no pointer byte; the bank keeps the last one.
    task automatic begin_xfer(input logic rnw);
        bus_busy_o  = 1'b1;
        req_o.start = 1'b1;
        req_o.rnw   = rnw;
        @(posedge mclk_i);
        #1;
        req_o = '0;
        @(posedge mclk_i);
        #1;
    endtask : begin_xfer
    task automatic put_byte(input logic [7:0] b, output logic [1:0] resp);
        req_o.wr_valid = 1'b1;
        req_o.wr_byte  = b;
        @(posedge mclk_i);
        #1;
        // The answer stands only in the cycle right after the strobe edge.
        resp  = {ans_i.ack_valid, ans_i.ack};
        req_o = '0;
        @(posedge mclk_i);
        #1;
    endtask : put_byte
    task automatic get_byte(output logic [7:0] b);
        req_o.rd_req = 1'b1;
        @(posedge mclk_i);
        #1;
        b     = ans_i.rd_valid ? ans_i.rd_byte : 8'hxx;
        req_o = '0;
        @(posedge mclk_i);
        #1;
    endtask : get_byte
    task automatic end_xfer();
        bus_busy_o = 1'b0;
        @(posedge mclk_i);
        #1;
    endtask : end_xfer
endmodule : tsr_host_model

`default_nettype wire

/* sim/tsr_register_bank_bench.sv */
`default_nettype none

module tsr_register_bank_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import tsr_pkg::*;
    localparam int          TO = 50;
    localparam logic [15:0] MK = 16'h0c3c; // Arbitrary value.
    localparam logic [15:0] PT = 16'h3c01; // Arbitrary value.
    localparam logic [15:0] PA = 16'h3c02; // Arbitrary value.
    localparam logic [15:0] CAP = {8'h00, 3'b111, 2'h1, 3'b111};
    logic        mclk_i = 1'b0;
    logic        resetn_i = 1'b0;
    tsr_req_t    req;
    tsr_ans_t    ans;
    logic        busy;
    logic        scl;
    logic        srst;
    logic [1:0]  step;
    logic [15:0] amb = 16'h1234;
    logic        evt = 1'b0;
    logic [15:0] cfg;
    tsr_limits_t lim;
    logic        iclr;
    int          clr_seen = 0;
    int          mismatches = 0;
    int          checked = 0;
    int          n;
    logic [15:0] tab [10] = '{CAP, 16'h0, 16'h0, 16'h0, 16'h0, 16'h1234, MK, PT, PA, 16'h1};
    always #2 mclk_i = ~mclk_i;
    // The clear strobe lasts one cycle, so it is counted mid-cycle where it is settled.
    always @(negedge mclk_i)
    begin
        if (iclr === 1'b1)
            clr_seen++;
    end
    tsr_host_model u_host (.mclk_i(mclk_i), .ans_i(ans), .req_o(req), .bus_busy_o(busy),
        .scl_o(scl));
    tsr_register_bank #(.BUS_TIMEOUT_CYCLES(TO), .MAKER_CODE(MK), .PART_CODE(PT),
        .PART_CODE_ALT(PA)) dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .req_i(req),
        .bus_busy_i(busy), .scl_i(scl), .ans_o(ans), .serial_reset_o(srst),
        .ambient_temperature_i(amb), .event_stat_i(evt), .config_o(cfg), .limits_o(lim),
        .step_size_o(step), .int_clear_o(iclr));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic set_ptr(input logic [7:0] p, input logic [1:0] exp);
        logic [1:0] r;
        u_host.begin_xfer(1'b0);
        u_host.put_byte(p, r);
        chk(16'(r), 16'(exp));
        u_host.end_xfer();
    endtask : set_ptr
    task automatic wr_reg(input logic [7:0] p, input logic [15:0] d);
        logic [1:0] r0;
        logic [1:0] r1;
        logic [1:0] r2;
        u_host.begin_xfer(1'b0);
        u_host.put_byte(p, r0);
        u_host.put_byte(d[15:8], r1);
        u_host.put_byte(d[7:0], r2);
        chk({10'h0, r0, r1, r2}, 16'h003f);
        u_host.end_xfer();
    endtask : wr_reg
    task automatic rd_cur(input logic [15:0] exp);
        logic [7:0] hi;
        logic [7:0] lo;
        u_host.begin_xfer(1'b1);
        u_host.get_byte(hi);
        u_host.get_byte(lo);
        u_host.end_xfer();
        chk({hi, lo}, exp);
    endtask : rd_cur
    task automatic finish_test();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    initial
    begin
        repeat (8) @(posedge mclk_i);
        #1;
        resetn_i = 1'b1;
        for (int i = 0; i < 10; i++)
        begin
            set_ptr(8'(i), 2'b11);
            rd_cur(tab[i]);
        end
        $display("test map done");
        set_ptr(8'h00, 2'b11);
        wr_reg(8'h00, 16'hffff);
        rd_cur(CAP);
        rd_cur(CAP);
        $display("test read only done");
        for (int c = 0; c < 4; c++)
        begin
            wr_reg(8'h09, 16'(c));
            chk(16'(step), 16'(c));
            set_ptr(8'h00, 2'b11);
            rd_cur({8'h00, 3'b111, 2'(c), 3'b111});
        end
        wr_reg(8'h09, 16'h0001);
        $display("test step size done");
        set_ptr(8'h05, 2'b11);
        set_ptr(8'h0a, 2'b10);
        set_ptr(8'h10, 2'b10);
        rd_cur(16'h1234);
        $display("test pointer done");
        u_host.begin_xfer(1'b1);
        u_host.scl_hold = 1'b1;
        n = 0;
        while (srst !== 1'b1 && n < 2 * TO)
        begin
            @(posedge mclk_i);
            #1;
            n++;
        end
        chk(16'(n >= TO - 1 && n <= TO + 4), 16'h0001);
        u_host.scl_hold = 1'b0;
        u_host.end_xfer();
        rd_cur(16'h1234);
        $display("test timeout done");
        wr_reg(8'h02, 16'hffff);
        chk(lim.upper, 16'hffff & LIMIT_WRITE_MASK);
        wr_reg(8'h01, 16'h0060);
        chk(cfg, 16'h0060 & CFG_STORE_MASK);
        chk(16'(clr_seen), 16'h0001);
        wr_reg(8'h02, 16'h0000);
        wr_reg(8'h04, 16'h0abc);
        chk(lim.upper, 16'hffff & LIMIT_WRITE_MASK);
        chk(lim.critical, 16'h0abc & LIMIT_WRITE_MASK);
        evt = 1'b1;
        amb = 16'hc123;
        set_ptr(8'h01, 2'b11);
        rd_cur((16'h0060 & CFG_STORE_MASK) | 16'(1 << CFG_EVENT_STAT_BIT));
        set_ptr(8'h05, 2'b11);
        rd_cur(16'hc123);
        evt = 1'b0;
        $display("test config and limits done");
        wr_reg(8'h09, 16'h0003);
        resetn_i = 1'b0;
        repeat (2) @(posedge mclk_i);
        #1;
        resetn_i = 1'b1;
        chk(cfg, CONFIG_RESET);
        chk(lim.upper, LIMIT_RESET);
        chk(16'(step), 16'(STEP_SIZE_RESET));
        rd_cur(CAP);
        $display("test reset done");
        finish_test();
    end
endmodule : tsr_register_bank_bench

`default_nettype wire
